// ### logic/synth_post_divider_cfg.svh
// Register addresses, field positions and reset values for the post dividers
`ifndef SYNTH_POST_DIVIDER_CFG_SVH
`define SYNTH_POST_DIVIDER_CFG_SVH

`define PD_C_ADDR      8'h92
`define PD_D_ADDR      8'h95
`define PD_RESET_VAL   24'h000032
`define PD_SHAPE_MSB   23
`define PD_SHAPE_LSB   20
`define PD_FRAME_SHAPE 4'hF
`define PD_TYPE_BIT    19
`define PD_POL_BIT     18
`define PD_SEL_MSB     17
`define PD_SEL_LSB     16
`define PD_PERIOD_MSB  15
`define PD_MIN_RATIO   24'h000002
`define PD_MIN_PERIOD  16'h0001
`define PD_SEL_A       2'h0
`define PD_SEL_B       2'h1
`define PD_SEL_2       2'h2
`define PD_SEL_3       2'h3
`define PD_BYTE_HI     2'h0
`define PD_BYTE_MID    2'h1
`define PD_BYTE_LO     2'h2
`define PD_ALL_BYTES   3'h7

`endif

// ### logic/synth_post_divider_frame_pulse.sv
// Post divider channels C and D: divided clock or frame pulse output
`timescale 1ns/1ps
`include "synth_post_divider_cfg.svh"

module synth_post_divider_frame_pulse (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       rel_a_clk,
  input  wire logic       rel_b_clk,
  input  wire logic       pin_route_c,
  input  wire logic       pin_route_d,
  output logic      [7:0] reg_rdata_q,
  output logic            clk_out_c_q,
  output logic            clk_out_d_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] eff_ratio(input logic [23:0] r);
    eff_ratio = (r < `PD_MIN_RATIO) ? `PD_MIN_RATIO : r;
  endfunction

  function automatic logic [15:0] eff_period(input logic [15:0] p);
    eff_period = (p < `PD_MIN_PERIOD) ? `PD_MIN_PERIOD : p;
  endfunction

  function automatic logic is_frame(input logic [23:0] s);
    is_frame = (s[`PD_SHAPE_MSB:`PD_SHAPE_LSB] == `PD_FRAME_SHAPE);
  endfunction

  // Related clock pick; own-channel code reads as reserved (low)
  function automatic logic rel_pick(
    input logic       is_d,
    input logic [1:0] sel,
    input logic       a,
    input logic       b,
    input logic       c_lvl,
    input logic       d_lvl
  );
    case (sel)
      `PD_SEL_A: rel_pick = a;
      `PD_SEL_B: rel_pick = b;
      `PD_SEL_2: rel_pick = is_d ? c_lvl : 1'b0;
      `PD_SEL_3: rel_pick = is_d ? 1'b0 : d_lvl;
      default:   rel_pick = 1'b0;
    endcase
  endfunction

  // Own-channel and reserved codes give no related clock
  function automatic logic rel_valid(
    input logic       is_d,
    input logic [1:0] sel
  );
    rel_valid = is_d ? (sel != `PD_SEL_3) : (sel != `PD_SEL_2);
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  synth_post_divider_pkg::setting_t   stage_q [2];
  synth_post_divider_pkg::setting_t   stage_d [2];
  synth_post_divider_pkg::setting_t   cfg_q   [2];
  synth_post_divider_pkg::setting_t   cfg_d   [2];
  logic [2:0]                         wmask_q [2];
  logic [2:0]                         wmask_d [2];
  synth_post_divider_pkg::chan_mode_t mode_q  [2];
  synth_post_divider_pkg::chan_mode_t mode_d  [2];
  logic [7:0]                         rdata_d;

  always_comb
  begin
    logic [7:0] base;
    logic [7:0] off;
    base    = 8'h00;
    off     = 8'h00;
    rdata_d = 8'h00;
    for (int k = 0; k < 2; k++)
    begin
      base       = (k == 0) ? `PD_C_ADDR : `PD_D_ADDR;
      off        = reg_addr - base;
      stage_d[k] = stage_q[k];
      cfg_d[k]   = cfg_q[k];
      wmask_d[k] = wmask_q[k];
      mode_d[k]  = mode_q[k];
      if (reg_addr >= base && off <= {6'h00, `PD_BYTE_LO})
      begin
        case (off[1:0])
          `PD_BYTE_HI:  rdata_d = stage_q[k][23:16];
          `PD_BYTE_MID: rdata_d = stage_q[k][15:8];
          default:      rdata_d = stage_q[k][7:0];
        endcase
        if (reg_wr)
        begin
          case (off[1:0])
            `PD_BYTE_HI:  stage_d[k][23:16] = reg_wdata;
            `PD_BYTE_MID: stage_d[k][15:8]  = reg_wdata;
            default:      stage_d[k][7:0]   = reg_wdata;
          endcase
          wmask_d[k][off[1:0]] = 1'b1;
          if (wmask_d[k] == `PD_ALL_BYTES)
          begin
            cfg_d[k]   = stage_d[k];
            wmask_d[k] = 3'h0;
            if (is_frame(stage_d[k]))
              mode_d[k] = synth_post_divider_pkg::MODE_FRAME;
            else
              mode_d[k] = synth_post_divider_pkg::MODE_CLOCK;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int k = 0; k < 2; k++)
      begin
        stage_q[k] <= `PD_RESET_VAL;
        cfg_q[k]   <= `PD_RESET_VAL;
        wmask_q[k] <= 3'h0;
        mode_q[k]  <= synth_post_divider_pkg::MODE_CLOCK;
      end
      reg_rdata_q <= 8'h00;
    end
    else
    begin
      stage_q     <= stage_d;
      cfg_q       <= cfg_d;
      wmask_q     <= wmask_d;
      mode_q      <= mode_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Dividers and frame pulse generators (index 0 is C, 1 is D)
  // ----------------------------------------------------------------
  logic [23:0] cnt_q   [2];
  logic [23:0] cnt_d   [2];
  logic        lvl_q   [2];
  logic        lvl_d   [2];
  logic [15:0] fcnt_q  [2];
  logic [15:0] fcnt_d  [2];
  logic        rprev_q [2];
  logic        rprev_d [2];
  logic        fp_q    [2];
  logic        fp_d    [2];
  logic        out_d   [2];

  always_comb
  begin
    logic [23:0] r;
    logic [15:0] p;
    logic        rel;
    logic        rise;
    logic        fall;
    logic        route;
    r     = 24'h000000;
    p     = 16'h0000;
    rel   = 1'b0;
    rise  = 1'b0;
    fall  = 1'b0;
    route = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      // Divided clock, high for floor(ratio/2) cycles
      r        = eff_ratio(cfg_q[k]);
      cnt_d[k] = (cnt_q[k] >= r - 24'h000001) ? 24'h000000
                 : cnt_q[k] + 24'h000001;
      lvl_d[k] = (cnt_d[k] < {1'b0, r[23:1]});

      rel = rel_pick(k == 1, cfg_q[k][`PD_SEL_MSB:`PD_SEL_LSB],
                     rel_a_clk, rel_b_clk, lvl_q[0], lvl_q[1]);
      rise       = rel && !rprev_q[k];
      fall       = !rel && rprev_q[k];
      rprev_d[k] = rel;
      p          = eff_period(cfg_q[k][`PD_PERIOD_MSB:0]);
      fcnt_d[k]  = fcnt_q[k];
      fp_d[k]    = fp_q[k];
      if (rise)
      begin
        // Counter holds index of the coming related rising edge
        fcnt_d[k] = (fcnt_q[k] >= p - 16'h0001) ? 16'h0000
                    : fcnt_q[k] + 16'h0001;
        if (cfg_q[k][`PD_TYPE_BIT])
          fp_d[k] = (fcnt_q[k] == 16'h0000);
      end
      if (fall && !cfg_q[k][`PD_TYPE_BIT])
        fp_d[k] = (fcnt_q[k] == 16'h0000);
      // No related clock: pulse idles instead of sticking
      if (!rel_valid(k == 1, cfg_q[k][`PD_SEL_MSB:`PD_SEL_LSB]))
        fp_d[k] = 1'b0;

      route = (k == 0) ? pin_route_c : pin_route_d;
      case (mode_q[k])
        synth_post_divider_pkg::MODE_FRAME:
          out_d[k] = fp_q[k] ^ cfg_q[k][`PD_POL_BIT] ^ route;
        synth_post_divider_pkg::MODE_CLOCK:
          out_d[k] = lvl_q[k];
        default:
          out_d[k] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int k = 0; k < 2; k++)
      begin
        cnt_q[k]   <= 24'h000000;
        lvl_q[k]   <= 1'b1;
        fcnt_q[k]  <= 16'h0000;
        rprev_q[k] <= 1'b0;
        fp_q[k]    <= 1'b0;
      end
      clk_out_c_q <= 1'b0;
      clk_out_d_q <= 1'b0;
    end
    else
    begin
      cnt_q       <= cnt_d;
      lvl_q       <= lvl_d;
      fcnt_q      <= fcnt_d;
      rprev_q     <= rprev_d;
      fp_q        <= fp_d;
      clk_out_c_q <= out_d[0];
      clk_out_d_q <= out_d[1];
    end
  end

endmodule

// ### logic/synth_post_divider_pkg.sv
// Types shared by the post divider channels
package synth_post_divider_pkg;

  typedef enum logic [1:0] {
    MODE_CLOCK = 2'b01,
    MODE_FRAME = 2'b10
  } chan_mode_t;

  typedef logic [23:0] setting_t;

endpackage

// ### testbench/synth_post_divider_monitor.sv
// Assertion checker for the post divider ports
`timescale 1ns/1ps
module synth_post_divider_monitor (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       clk_out_c_q,
  input wire logic       clk_out_d_q
);
  logic       map;
  logic       seen_q;
  logic       cp_q;
  logic       rs_q;
  logic [7:0] img;
  logic [7:0] hc_q;
  logic [7:0] hd_q;
  logic [7:0] pc_q;
  assign map = reg_addr >= 8'h92 && reg_addr <= 8'h97;
  assign img = (reg_addr == 8'h94 || reg_addr == 8'h97) ? 8'h32 : 8'h00;
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      {seen_q, cp_q, rs_q, hc_q, hd_q, pc_q} <= '0;
    else
    begin
      seen_q <= seen_q | (reg_wr & map);
      cp_q   <= clk_out_c_q;
      rs_q   <= rs_q | (clk_out_c_q & ~cp_q);
      hc_q   <= clk_out_c_q ? hc_q + 8'h01 : 8'h00;
      hd_q   <= clk_out_d_q ? hd_q + 8'h01 : 8'h00;
      pc_q   <= (clk_out_c_q & ~cp_q) ? 8'h01 : pc_q + 8'h01;
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_wr;
    reg_wr && map;
  endsequence
  sequence s_rd_same;
    !reg_wr && $stable(reg_addr);
  endsequence
  chk_unmapped_zero:
    assert property (!map |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  chk_write_readback:
    assert property (s_wr ##1 s_rd_same |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("readback differs from written byte");
  chk_read_steady:
    assert property (!reg_wr && $stable(reg_addr) && !$past(reg_wr)
      && !$past(reset) |=> $stable(reg_rdata_q))
    else $error("read data moved without a write");
  chk_reset_image:
    assert property (!seen_q && !reg_wr && map |=> reg_rdata_q == $past(img))
    else $error("reset value wrong");
  chk_reset_outputs:
    assert property ($fell(reset) |-> !clk_out_c_q && !clk_out_d_q)
    else $error("outputs not low out of reset");
  chk_c_high_run:
    assert property ($fell(clk_out_c_q) && !seen_q |-> hc_q == 8'h19)
    else $error("default high time wrong on c");
  chk_d_high_run:
    assert property ($fell(clk_out_d_q) && !seen_q |-> hd_q == 8'h19)
    else $error("default high time wrong on d");
  chk_c_period:
    assert property ($rose(clk_out_c_q) && rs_q && !seen_q |-> pc_q == 8'h32)
    else $error("default period wrong on c");
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the post divider channels
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin check_count++; if ((got) !== (exp)) \
  begin n_mismatch++; $display("unexpected t=%0t got=%h exp=%h", \
  $time, got, exp); end end
module tb_top;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr = 8'h94;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       rel_a_clk = 1'b0;
  logic       pin_route_c = 1'b0;
  logic       pin_route_d = 1'b0;
  logic       rel_b_clk = 1'b0;
  logic [2:0] rel_cnt = 3'h0;
  logic [7:0] reg_rdata_q;
  logic       clk_out_c_q;
  logic       clk_out_d_q;
  int         n_mismatch = 0;
  int         check_count = 0;
  int         cc;
  int         cd;
  always #50 ref_clk = ~ref_clk;
  // Related clocks: a four cycles per period, b eight
  always @(posedge ref_clk)
  begin
    rel_cnt   <= rel_cnt + 3'h1;
    rel_a_clk <= rel_cnt[1];
    rel_b_clk <= rel_cnt[2];
  end
  synth_post_divider_frame_pulse DUT (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .rel_a_clk(rel_a_clk),
    .rel_b_clk(rel_b_clk), .pin_route_c(pin_route_c),
    .pin_route_d(pin_route_d), .reg_rdata_q(reg_rdata_q),
    .clk_out_c_q(clk_out_c_q), .clk_out_d_q(clk_out_d_q));
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr3(input logic [7:0] b, input logic [23:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      reg_addr  <= b + 8'(i);
      reg_wdata <= v[23 - 8 * i -: 8];
      reg_wr    <= 1'b1;
    end
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    `CHECK_EQ(reg_rdata_q, e)
  endtask
  task automatic meas(input int n);
    cc = 0;
    cd = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      cc += int'(clk_out_c_q === 1'b1);
      cd += int'(clk_out_d_q === 1'b1);
    end
  endtask
  task automatic frm(input logic [7:0] b, input logic [23:0] v,
                     input logic rt, input int n, input int e);
    wr3(b, v, 3);
    pin_route_c <= rt & (b == 8'h92);
    pin_route_d <= rt & (b == 8'h95);
    repeat (40) @(posedge ref_clk);
    meas(n);
    `CHECK_EQ((b == 8'h92) ? cc : cd, e)
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (120) @(posedge ref_clk);
    meas(100);
    `CHECK_EQ(cc + cd, 100)
    for (int a = 8'h91; a < 8'h99; a++)
      rd(a[7:0], (a == 8'h94 || a == 8'h97) ? 8'h32 : 8'h00);
    $display("test reset_image done");
    wr3(8'h92, 24'h000004, 3);
    wr3(8'h95, 24'h000005, 3);
    rd(8'h97, 8'h05);
    repeat (20) @(posedge ref_clk);
    meas(40);
    `CHECK_EQ(cc, 20)
    `CHECK_EQ(cd, 16)
    $display("test clock_ratio done");
    wr3(8'h92, 24'h000007, 2);
    repeat (20) @(posedge ref_clk);
    meas(84);
    `CHECK_EQ(cc, 42)
    wr3(8'h92, 24'h000007, 3);
    repeat (20) @(posedge ref_clk);
    meas(84);
    `CHECK_EQ(cc, 36)
    $display("test byte_commit done");
    frm(8'h95, 24'hF80003, 1'b0, 48, 16);
    frm(8'h95, 24'hF90003, 1'b0, 48, 16);
    frm(8'h95, 24'hF40003, 1'b0, 48, 32);
    frm(8'h95, 24'hF40003, 1'b1, 48, 16);
    frm(8'h95, 24'hF70003, 1'b0, 48, 48);
    frm(8'h95, 24'hF20003, 1'b0, 84, 28);
    $display("test frame_d done");
    wr3(8'h95, 24'h000006, 3);
    frm(8'h92, 24'hF30003, 1'b0, 72, 24);
    frm(8'h92, 24'hF20003, 1'b0, 72, 0);
    $display("test frame_c done");
    end_sim();
  end
endmodule
bind synth_post_divider_frame_pulse synth_post_divider_monitor u_mon (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata_q(reg_rdata_q),
  .clk_out_c_q(clk_out_c_q), .clk_out_d_q(clk_out_d_q));
